// [pkg/thermal_ctrl_pkg.sv]
package thermal_ctrl_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] THERMAL_CTRL_FIRST_OFS = 12'hcd8;
   localparam logic [11:0] THERMAL_CTRL_SECOND_OFS = 12'hcd9;
   localparam logic [7:0] THERMAL_CTRL_FIRST_RST = 8'h00;
   localparam logic [7:0] THERMAL_CTRL_SECOND_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ---------------------------------------------------------------
   // field positions, first register
   // ---------------------------------------------------------------
   localparam int POWER_EN_BIT = 7;
   localparam int ANALOG_HYST_BIT = 6;
   localparam int DIG_HYST_LSB = 2;
   localparam int DIG_HYST_MSB = 5;
   localparam int CMP_SEL_BIT = 1;
   localparam int SEMAPHORE_BIT = 0;

   // ---------------------------------------------------------------
   // field positions, second register
   // ---------------------------------------------------------------
   localparam int RATE_LSB = 0;
   localparam int RATE_MSB = 3;
   localparam logic [3:0] RATE_ANALOG_MODE = 4'h0;
   localparam logic [3:0] SECOND_RSVD = 4'h0;

   // comparator select encodings
   localparam logic CMP_CATASTROPHIC = 1'b0;
   localparam logic CMP_HOT = 1'b1;
endpackage

// [pkg/thermal_sem_if.sv]
`timescale 1ns/1ps
// carrier between register block and ownership semaphore
interface thermal_sem_if;
   logic read_hit;
   logic clear_req;
   logic sem_state;
   modport ctrl (output read_hit, output clear_req, input sem_state);
   modport sem (input read_hit, input clear_req, output sem_state);
endinterface

// [hw/thermal_sem.sv]
`timescale 1ns/1ps
module thermal_sem
   import thermal_ctrl_pkg::*;
(
   // clock and reset, low while either the platform reset or the main reset is low
   input wire logic core_clk_i,
   input wire logic sem_rst_n_i,
   // register side
   thermal_sem_if.sem sem_if
);
   logic ownership_semaphore_reg;
   logic ownership_semaphore_next;

   // -----------------------------------------------------------------
   // read sets, write of one clears; set wins on a tie
   // -----------------------------------------------------------------
   always_comb begin
      ownership_semaphore_next = ownership_semaphore_reg;
      if (sem_if.clear_req) begin
         ownership_semaphore_next = 1'b0;
      end
      if (sem_if.read_hit) begin
         ownership_semaphore_next = 1'b1;
      end
   end

   // only platform reset and main reset touch this bit
   always_ff @(posedge core_clk_i or negedge sem_rst_n_i) begin
      if (!sem_rst_n_i) begin
         ownership_semaphore_reg <= THERMAL_CTRL_FIRST_RST[SEMAPHORE_BIT];
      end else begin
         ownership_semaphore_reg <= ownership_semaphore_next;
      end
   end

   assign sem_if.sem_state = ownership_semaphore_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_sem_read_sets: assert property (@(posedge core_clk_i) disable iff (!sem_rst_n_i)
      sem_if.read_hit |=> ownership_semaphore_reg)
      else $error("semaphore not set after read");
   a_sem_clear_one: assert property (@(posedge core_clk_i) disable iff (!sem_rst_n_i)
      (sem_if.clear_req && !sem_if.read_hit) |=> !ownership_semaphore_reg)
      else $error("semaphore not cleared by write of one");
   a_sem_hold_idle: assert property (@(posedge core_clk_i) disable iff (!sem_rst_n_i)
      (!sem_if.clear_req && !sem_if.read_hit) |=> $stable(ownership_semaphore_reg))
      else $error("semaphore changed without access");
endmodule

// [hw/thermal_ctrl_regs.sv]
`timescale 1ns/1ps
module thermal_ctrl_regs
   import thermal_ctrl_pkg::*;
(
   // clock and resets
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic platform_reset_n_i,
   // register access port
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // lock from the lock control register
   input wire logic lock_active_i,
   // sensor controls
   output logic sensor_power_enable_o,
   output logic analog_hyst_enable_o,
   output logic [3:0] digital_hyst_amount_o,
   output logic comparator_select_o,
   output logic [3:0] thermometer_rate_o,
   output logic analog_mode_o,
   // comparator mux
   input wire logic cat_cmp_i,
   input wire logic hot_cmp_i,
   output logic cmp_out_o,
   // trip threshold with digital hysteresis
   input wire logic [7:0] trip_temp_i,
   input wire logic tripped_i,
   output logic [7:0] trip_threshold_o
);
   // nrst_i is the main power-good reset domain
   logic sem_rst_n;
   thermal_sem_if sem_bus ();

   // first register fields (bits 7:1)
   logic power_en_reg;
   logic power_en_next;
   logic analog_hyst_reg;
   logic analog_hyst_next;
   logic [3:0] dig_hyst_reg;
   logic [3:0] dig_hyst_next;
   logic cmp_sel_reg;
   logic cmp_sel_next;
   // second register field
   logic [3:0] rate_reg;
   logic [3:0] rate_next;
   // read path
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   // derived datapath
   logic cmp_out_reg;
   logic cmp_out_next;
   logic [7:0] trip_thr_reg;
   logic [7:0] trip_thr_next;

   logic first_hit;
   logic second_hit;

   // offset added to a trip point once tripped, saturating at the top
   function automatic logic [7:0] hyst_threshold(input logic [7:0] base,
                                                 input logic [3:0] amount,
                                                 input logic hit);
      logic [8:0] sum;
      sum = {1'b0, base} + (hit ? {5'h00, amount} : 9'h000);
      return sum[8] ? 8'hff : sum[7:0];
   endfunction

   // -----------------------------------------------------------------
   // address decode and semaphore hookup
   // -----------------------------------------------------------------
   assign first_hit = (reg_addr_i == THERMAL_CTRL_FIRST_OFS);
   assign second_hit = (reg_addr_i == THERMAL_CTRL_SECOND_OFS);
   // semaphore also falls with the main reset, a full reset clears all
   assign sem_rst_n = nrst_i & platform_reset_n_i;
   assign sem_bus.read_hit = reg_rd_i & first_hit;
   assign sem_bus.clear_req = reg_wr_i & first_hit & reg_wdata_i[SEMAPHORE_BIT];

   thermal_sem u_sem (
      .core_clk_i(core_clk_i),
      .sem_rst_n_i(sem_rst_n),
      .sem_if(sem_bus)
   );

   // -----------------------------------------------------------------
   // control field next values
   // -----------------------------------------------------------------
   always_comb begin
      power_en_next = power_en_reg;
      analog_hyst_next = analog_hyst_reg;
      dig_hyst_next = dig_hyst_reg;
      cmp_sel_next = cmp_sel_reg;
      rate_next = rate_reg;
      if (reg_wr_i && first_hit) begin
         analog_hyst_next = reg_wdata_i[ANALOG_HYST_BIT];
         dig_hyst_next = reg_wdata_i[DIG_HYST_MSB:DIG_HYST_LSB];
         // locked fields keep their value
         if (!lock_active_i) begin
            power_en_next = reg_wdata_i[POWER_EN_BIT];
            cmp_sel_next = reg_wdata_i[CMP_SEL_BIT];
         end
      end
      // rate field is lockable as well
      if (reg_wr_i && second_hit && !lock_active_i) begin
         rate_next = reg_wdata_i[RATE_MSB:RATE_LSB];
      end
   end

   // bits 7:1 and the second register sit on the power-good reset only
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         power_en_reg <= THERMAL_CTRL_FIRST_RST[POWER_EN_BIT];
         analog_hyst_reg <= THERMAL_CTRL_FIRST_RST[ANALOG_HYST_BIT];
         dig_hyst_reg <= THERMAL_CTRL_FIRST_RST[DIG_HYST_MSB:DIG_HYST_LSB];
         cmp_sel_reg <= THERMAL_CTRL_FIRST_RST[CMP_SEL_BIT];
         rate_reg <= THERMAL_CTRL_SECOND_RST[RATE_MSB:RATE_LSB];
      end else begin
         power_en_reg <= power_en_next;
         analog_hyst_reg <= analog_hyst_next;
         dig_hyst_reg <= dig_hyst_next;
         cmp_sel_reg <= cmp_sel_next;
         rate_reg <= rate_next;
      end
   end

   // -----------------------------------------------------------------
   // read path, one cycle after the strobe
   // -----------------------------------------------------------------
   always_comb begin
      rvalid_next = reg_rd_i;
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         if (first_hit) begin
            // semaphore shows its value before this read sets it
            rdata_next = {power_en_reg, analog_hyst_reg, dig_hyst_reg,
                          cmp_sel_reg, sem_bus.sem_state};
         end else if (second_hit) begin
            rdata_next = {SECOND_RSVD, rate_reg};
         end else begin
            rdata_next = UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // -----------------------------------------------------------------
   // sensor datapath; the semaphore feeds none of it
   // -----------------------------------------------------------------
   always_comb begin
      // gated on power so an unpowered sensor reports nothing
      cmp_out_next = power_en_reg & ((cmp_sel_reg == CMP_HOT) ? hot_cmp_i : cat_cmp_i);
      trip_thr_next = hyst_threshold(trip_temp_i, dig_hyst_reg, tripped_i);
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmp_out_reg <= 1'b0;
         trip_thr_reg <= 8'h00;
      end else begin
         cmp_out_reg <= cmp_out_next;
         trip_thr_reg <= trip_thr_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata_o = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;
   assign sensor_power_enable_o = power_en_reg;
   assign analog_hyst_enable_o = analog_hyst_reg;
   assign digital_hyst_amount_o = dig_hyst_reg;
   assign comparator_select_o = cmp_sel_reg;
   assign thermometer_rate_o = rate_reg;
   assign analog_mode_o = (rate_reg == RATE_ANALOG_MODE);
   assign cmp_out_o = cmp_out_reg;
   assign trip_threshold_o = trip_thr_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_lock_power_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_wr_i && first_hit && lock_active_i) |=> $stable(power_en_reg) && $stable(cmp_sel_reg))
      else $error("locked field changed on write");
   a_power_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_wr_i && first_hit && !lock_active_i) |=> power_en_reg == $past(reg_wdata_i[7]))
      else $error("sensor power enable did not take write");
   a_cmp_sel_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_wr_i && first_hit && !lock_active_i) |=> cmp_sel_reg == $past(reg_wdata_i[1]))
      else $error("comparator select did not take write");
   a_hyst_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_wr_i && first_hit) |=> dig_hyst_reg == $past(reg_wdata_i[5:2])
                                  && analog_hyst_reg == $past(reg_wdata_i[6]))
      else $error("hysteresis fields did not take write");
   a_sem_read_pair: assert property (@(posedge core_clk_i) disable iff (!sem_rst_n)
      (reg_rd_i && first_hit) ##1 (reg_rd_i && first_hit && !reg_wr_i)
      |=> reg_rvalid_o && reg_rdata_o[0])
      else $error("second semaphore read did not return one");
   a_sem_read_value: assert property (@(posedge core_clk_i) disable iff (!sem_rst_n)
      (reg_rd_i && first_hit) |=> reg_rdata_o[0] == $past(sem_bus.sem_state))
      else $error("semaphore read value wrong");
   a_second_layout: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_rd_i && second_hit) |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3:0] == $past(rate_reg))
      else $error("second register read wrong");
   a_first_fields: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (reg_rd_i && first_hit) |=> reg_rdata_o[7:1] == $past({power_en_reg, analog_hyst_reg,
                                                             dig_hyst_reg, cmp_sel_reg}))
      else $error("first register read wrong");
   a_mode_select: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      analog_mode_o == (thermometer_rate_o == 4'h0))
      else $error("analog mode flag wrong");
   a_cmp_mux: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ##1 cmp_out_o == $past(power_en_reg & (cmp_sel_reg ? hot_cmp_i : cat_cmp_i)))
      else $error("comparator output wrong");
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import thermal_ctrl_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic platform_reset_n_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic lock_active_i = 1'b0;
   logic cat_cmp_i = 1'b0;
   logic hot_cmp_i = 1'b0;
   logic [7:0] trip_temp_i = 8'h00;
   logic tripped_i = 1'b0;
   logic [7:0] reg_rdata_o, trip_threshold_o;
   logic reg_rvalid_o, sensor_power_enable_o, analog_hyst_enable_o, comparator_select_o;
   logic [3:0] digital_hyst_amount_o, thermometer_rate_o;
   logic analog_mode_o, cmp_out_o;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 33717;
   logic [7:0] rv, w, held;

   thermal_ctrl_regs i_thermal_ctrl_regs (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .platform_reset_n_i(platform_reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .lock_active_i(lock_active_i), .sensor_power_enable_o(sensor_power_enable_o),
      .analog_hyst_enable_o(analog_hyst_enable_o),
      .digital_hyst_amount_o(digital_hyst_amount_o),
      .comparator_select_o(comparator_select_o), .thermometer_rate_o(thermometer_rate_o),
      .analog_mode_o(analog_mode_o), .cat_cmp_i(cat_cmp_i), .hot_cmp_i(hot_cmp_i),
      .cmp_out_o(cmp_out_o), .trip_temp_i(trip_temp_i), .tripped_i(tripped_i),
      .trip_threshold_o(trip_threshold_o));

   // free-running 100 MHz clock
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end

   // hang guard, well above the roughly 160 cycles the sequence needs
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // checks and bus tasks
   // ---------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // strobes rise one edge after the previous task dropped them
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      #1 reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge core_clk_i);
      #1 reg_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b0;
      chk1("rvalid", 1'b1, reg_rvalid_o);
      d = reg_rdata_o;
   endtask

   // trip point plus hysteresis once tripped, clipped at full scale
   function automatic logic [7:0] exp_thr(input logic [7:0] t, input logic tr,
                                          input logic [3:0] a);
      logic [8:0] s;
      s = {1'b0, t} + (tr ? {5'h00, a} : 9'h000);
      return s[8] ? 8'hff : s[7:0];
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk_i);
      #1 nrst_i = 1'b1;
      platform_reset_n_i = 1'b1;
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("first_reset", 8'h00, rv);
      rd(THERMAL_CTRL_SECOND_OFS, rv);
      chk8("second_reset", 8'h00, rv);
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("sem_after_read", 8'h01, rv);
      rd(12'h123, rv);
      chk8("unmapped", 8'h00, rv);
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("sem_sticky", 8'h01, rv);
      // unlocked field writes with the recommended code among them
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 8'h18 : (i == 1) ? 8'hfe : 8'($random(seed));
         wr(THERMAL_CTRL_FIRST_OFS, w | 8'h01);
         chk1("power_en", w[7], sensor_power_enable_o);
         chk1("ahyst", w[6], analog_hyst_enable_o);
         chk8("dhyst", {4'h0, w[5:2]}, {4'h0, digital_hyst_amount_o});
         chk1("cmp_sel", w[1], comparator_select_o);
         rd(THERMAL_CTRL_FIRST_OFS, rv);
         chk8("sem_cleared", {w[7:1], 1'b0}, rv);
         rd(THERMAL_CTRL_FIRST_OFS, rv);
         chk8("sem_set", {w[7:1], 1'b1}, rv);
         wr(THERMAL_CTRL_FIRST_OFS, {w[7:1], 1'b0});
         rd(THERMAL_CTRL_FIRST_OFS, rv);
         chk8("sem_write0", {w[7:1], 1'b1}, rv);
         chk1("sem_no_effect", w[7], sensor_power_enable_o);
         // comparator mux and trip threshold follow the fields
         for (int j = 0; j < 8; j++) begin
            cat_cmp_i = j[0];
            hot_cmp_i = j[1];
            tripped_i = j[2];
            trip_temp_i = (j == 7) ? 8'hfe : 8'($random(seed));
            @(posedge core_clk_i);
            #1 chk1("cmp_out", w[7] & (w[1] ? j[1] : j[0]), cmp_out_o);
            chk8("threshold", exp_thr(trip_temp_i, j[2], w[5:2]), trip_threshold_o);
         end
      end
      // analog hysteresis off before thermometer mode; bit 0 kept 0 so the semaphore stays
      w = w & 8'hbe;
      wr(THERMAL_CTRL_FIRST_OFS, w);
      chk1("ahyst_off", 1'b0, analog_hyst_enable_o);
      // rate field and analog mode, then lock
      wr(THERMAL_CTRL_SECOND_OFS, 8'hf3);
      rd(THERMAL_CTRL_SECOND_OFS, rv);
      chk8("second_rsvd", 8'h03, rv);
      chk1("analog_mode_off", 1'b0, analog_mode_o);
      held = w;
      lock_active_i = 1'b1;
      w = 8'($random(seed)) & 8'hbe;
      wr(THERMAL_CTRL_FIRST_OFS, w);
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("locked_write", {held[7], w[6:2], held[1], 1'b1}, rv);
      wr(THERMAL_CTRL_SECOND_OFS, 8'h00);
      chk8("locked_rate", 8'h03, {4'h0, thermometer_rate_o});
      lock_active_i = 1'b0;
      wr(THERMAL_CTRL_SECOND_OFS, 8'h00);
      chk1("analog_mode_on", 1'b1, analog_mode_o);
      // platform reset drops only the semaphore
      platform_reset_n_i = 1'b0;
      @(posedge core_clk_i);
      #1 platform_reset_n_i = 1'b1;
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("platform_reset", {held[7], w[6:2], held[1], 1'b0}, rv);
      chk1("power_kept", held[7], sensor_power_enable_o);
      // main reset clears everything at once
      nrst_i = 1'b0;
      #1 chk1("power_cleared", 1'b0, sensor_power_enable_o);
      chk8("dhyst_cleared", 8'h00, {4'h0, digital_hyst_amount_o});
      @(posedge core_clk_i);
      #1 nrst_i = 1'b1;
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("main_reset", 8'h00, rv);
      // a reader that got 0 without wanting the sensor hands it back
      wr(THERMAL_CTRL_FIRST_OFS, 8'h01);
      rd(THERMAL_CTRL_FIRST_OFS, rv);
      chk8("sem_released", 8'h00, rv);
      // read and write of one in the same cycle: the set wins
      wr(THERMAL_CTRL_FIRST_OFS, 8'h01);
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b1;
      reg_wr_i = 1'b1;
      reg_addr_i = THERMAL_CTRL_FIRST_OFS;
      reg_wdata_i = 8'h01;
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b0;
      reg_wr_i = 1'b0;
      chk8("sem_tie_read", 8'h00, reg_rdata_o);
      // two reads back to back, both see the semaphore set
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b1;
      @(posedge core_clk_i);
      #1 chk8("sem_tie_won", 8'h01, reg_rdata_o);
      @(posedge core_clk_i);
      #1 reg_rd_i = 1'b0;
      chk8("sem_back_to_back", 8'h01, reg_rdata_o);
      test_done();
   end
endmodule
